/* File: rbm_pkg.sv */
package rbm_pkg;

  // system clock
  localparam int MCLK_MHZ   = 125;

  // internal reset hold after the last active source, and the self-issued pin pulse
  localparam int HOLD_NS    = 1000;
  localparam int PULSE_NS   = 2000;

  // least time: round up to whole cycles, never below one
  function automatic int ns_to_cycles_min(input int ns);
    int cyc;
    cyc = (ns * MCLK_MHZ + 999) / 1000;
    return (cyc < 1) ? 1 : cyc;
  endfunction

  localparam int HOLD_CYC   = ns_to_cycles_min(HOLD_NS);
  localparam int PULSE_CYC  = ns_to_cycles_min(PULSE_NS);
  localparam int CNT_W      = 9;

  // synchroniser lanes and their reset levels
  localparam int SYNC_W     = 3;
  localparam int SYNC_EXT   = 0;
  localparam int SYNC_ADAP  = 1;
  localparam int SYNC_STRAP = 2;
  // pin idles high (pull-up), adapter absent, strap floating high
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h5;

  // strap level that selects test mode
  localparam logic STRAP_TEST_LVL = 1'h0;

  typedef enum logic [1:0] {
    RBM_HOLD   = 2'h0,
    RBM_SAMPLE = 2'h1,
    RBM_PULSE  = 2'h2,
    RBM_RUN    = 2'h3
  } rbm_state_t;

  typedef struct packed {
    logic por;
    logic ext;
    logic wdt;
    logic sw;
  } rbm_cause_t;

  localparam rbm_cause_t CAUSE_POR = '{por: 1'h1, ext: 1'h0, wdt: 1'h0, sw: 1'h0};

endpackage

/* File: rbm_sync.sv */
`timescale 1ns/10ps
module rbm_sync import rbm_pkg::*; #(
  parameter int            W       = SYNC_W,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* File: rbm_reset_ctrl.sv */
`timescale 1ns/10ps
// How it works
// - a sequence starts on power-up, external pin low, watchdog timeout, or software reset request
// - power-up holds every circuit in reset until a defined state is reached
// - external pin low forces the same state as power-on; driven low only on request (here a pin reset keeps the test-mode flag and records ext as cause)
// - the external reset pin has a pull-up so a floating pin never holds reset
// - with adapter power, strap sampled at start-up: low is test, high/floating application
// - strap sampled high releases the pin for general-purpose use
// - strap low sets the test-mode flag, then resets through the external pin
// - leaving test mode: firmware clears the flag, then resets by pin or software
// - vendor commands over the serial port are accepted only in test mode
module rbm_reset_ctrl import rbm_pkg::*; #(
  parameter int HOLD_CYCLES  = HOLD_CYC,
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  // clock and power-on reset
  input  wire logic mclk,
  input  wire logic reset,
  // other reset sources, same clock
  input  wire logic watchdog_timeout_src,
  input  wire logic sw_reset_req,
  // external active-low reset pin, open drain
  input  wire logic ext_rst_n_in,
  output logic      ext_rst_n_out,
  output logic      ext_rst_n_oe,
  output logic      ext_pullup_en,
  // supply sense and mode strap pin
  input  wire logic adapter_supply_in,
  input  wire logic mode_strap_pin_in,
  output logic      mode_strap_pin_out,
  output logic      mode_strap_pin_oe,
  // general-purpose use of the strap pin
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  output logic      gpio_in,
  // firmware access to the test-mode flag
  input  wire logic fw_flag_wr,
  input  wire logic fw_flag_wdata,
  output logic      test_mode,
  // system side
  output logic      sys_reset,
  output logic      uart_cmd_en,
  output logic      strap_released,
  output rbm_cause_t reset_cause
);

  localparam logic [CNT_W-1:0] HOLD_LOAD  = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYCLES - 1);

  logic [SYNC_W-1:0] sync_q;
  rbm_state_t        st;
  rbm_state_t        next_st;
  logic [CNT_W-1:0]  cnt;

  // pins come from outside the clock domain
  rbm_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .d     ({mode_strap_pin_in, adapter_supply_in, ext_rst_n_in}),
    .q     (sync_q)
  );

  wire ext_low  = !sync_q[SYNC_EXT];
  wire adap_on  = sync_q[SYNC_ADAP];
  wire strap_s  = sync_q[SYNC_STRAP];
  wire cnt_done = (cnt == '0);

  // our own pulse on the pin must not restart the sequence it belongs to
  wire src_ext  = ext_low && (st != RBM_PULSE);
  wire src_wdt  = watchdog_timeout_src && (st != RBM_PULSE);
  wire src_sw   = sw_reset_req && (st != RBM_PULSE);
  wire any_src  = src_ext || src_wdt || src_sw;

  // strap only counts while the adapter supplies the part
  wire strap_test = adap_on && (strap_s == STRAP_TEST_LVL);
  // flag already set means the self-reset was done; avoids a reset loop
  wire set_test   = (st == RBM_SAMPLE) && !any_src && strap_test && !test_mode;
  wire clr_test   = fw_flag_wr && !fw_flag_wdata;
  wire wr_test    = fw_flag_wr && fw_flag_wdata;
  // hardware set wins over a firmware clear in the same cycle
  wire next_test  = set_test || wr_test || (test_mode && !clr_test);

  always_comb begin
    next_st = st;
    unique case (st)
      RBM_HOLD: begin
        if (any_src) begin
          next_st = RBM_HOLD;
        end else if (cnt_done) begin
          next_st = RBM_SAMPLE;
        end
      end
      RBM_SAMPLE: begin
        if (any_src) begin
          next_st = RBM_HOLD;
        end else if (set_test) begin
          next_st = RBM_PULSE;
        end else begin
          next_st = RBM_RUN;
        end
      end
      RBM_PULSE: begin
        if (cnt_done) begin
          next_st = RBM_HOLD;
        end
      end
      RBM_RUN: begin
        if (any_src) begin
          next_st = RBM_HOLD;
        end
      end
    endcase
  end

  // hold restarts while any source stays active, so a held pin keeps reset
  wire load_hold  = (next_st == RBM_HOLD) && ((st != RBM_HOLD) || any_src);
  wire load_pulse = (next_st == RBM_PULSE) && (st != RBM_PULSE);
  wire [CNT_W-1:0] next_cnt = load_hold  ? HOLD_LOAD :
                              load_pulse ? PULSE_LOAD :
                              cnt_done   ? cnt : cnt - 1'h1;

  wire rbm_cause_t next_cause = (st == RBM_RUN && any_src) ?
    rbm_cause_t'{por: 1'h0, ext: src_ext, wdt: src_wdt, sw: src_sw} : reset_cause;

  // pin stays an input through every reset so the strap can be read
  wire next_released = (next_st == RBM_RUN) &&
                       ((st == RBM_RUN) ? strap_released : !strap_test);
  wire next_sys_rst  = (next_st != RBM_RUN);
  wire next_drive    = (next_st == RBM_PULSE);

  always_ff @(posedge mclk) begin
    if (reset) begin
      st    <= RBM_HOLD;
      cnt   <= HOLD_LOAD;
    end else begin
      st    <= next_st;
      cnt   <= next_cnt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sys_reset   <= 1'h1;
      test_mode   <= 1'h0;
      uart_cmd_en <= 1'h0;
      reset_cause <= CAUSE_POR;
    end else begin
      sys_reset   <= next_sys_rst;
      test_mode   <= next_test;
      uart_cmd_en <= next_test && !next_sys_rst;
      reset_cause <= next_cause;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ext_rst_n_oe       <= 1'h0;
      ext_rst_n_out      <= 1'h1;
      ext_pullup_en      <= 1'h1;
      strap_released     <= 1'h0;
      mode_strap_pin_oe  <= 1'h0;
      mode_strap_pin_out <= 1'h0;
      gpio_in            <= 1'h1;
    end else begin
      // open drain: only ever pulls low
      ext_rst_n_oe       <= next_drive;
      ext_rst_n_out      <= !next_drive;
      ext_pullup_en      <= 1'h1;
      strap_released     <= next_released;
      mode_strap_pin_oe  <= next_released && gpio_oe;
      mode_strap_pin_out <= gpio_out;
      gpio_in            <= strap_s;
    end
  end

  chk_sources_reset: assert property (@(posedge mclk) disable iff (reset)
    (st == RBM_RUN && (watchdog_timeout_src || sw_reset_req)) |=>
      (sys_reset && !reset_cause.por && st == RBM_HOLD))
    else $error("watchdog or software source did not start a reset");

  chk_hold_asserts: assert property (@(posedge mclk) disable iff (reset)
    (st != RBM_RUN) |-> (sys_reset && !uart_cmd_en))
    else $error("internal reset not held outside run");

  chk_hold_to_sample: assert property (@(posedge mclk) disable iff (reset)
    (st == RBM_HOLD && cnt_done && !any_src) |=> (st == RBM_SAMPLE) ##1 (st != RBM_HOLD || any_src || $past(any_src)))
    else $error("hold did not end in strap sampling");

  chk_ext_forces: assert property (@(posedge mclk) disable iff (reset)
    (st == RBM_RUN && ext_low) |=> (sys_reset && reset_cause.ext && st == RBM_HOLD))
    else $error("external pin low did not force reset");

  chk_pin_pullup: assert property (@(posedge mclk) disable iff (reset)
    ext_pullup_en && !(ext_rst_n_oe && ext_rst_n_out))
    else $error("reset pin pull-up off or pin driven high");

  chk_strap_test: assert property (@(posedge mclk) disable iff (reset)
    (st == RBM_SAMPLE && !any_src && strap_test) |=> (test_mode && !strap_released))
    else $error("strap low with adapter did not select test mode");

  chk_strap_release: assert property (@(posedge mclk) disable iff (reset)
    (st == RBM_SAMPLE && !any_src && !strap_test) |=> strap_released ##0 (st == RBM_RUN))
    else $error("strap high did not release the pin");

  chk_strap_input: assert property (@(posedge mclk) disable iff (reset)
    (!strap_released || sys_reset) |-> !mode_strap_pin_oe)
    else $error("strap pin driven while not released");

  chk_self_reset: assert property (@(posedge mclk) disable iff (reset)
    (set_test && st == RBM_SAMPLE) |=>
      (st == RBM_PULSE && test_mode && ext_rst_n_oe && !ext_rst_n_out) ##1 ext_rst_n_oe)
    else $error("test strap did not pulse the reset pin");

  chk_flag_clear: assert property (@(posedge mclk) disable iff (reset)
    (clr_test && !set_test) |=> !test_mode)
    else $error("firmware clear of the test flag lost");

  chk_uart_gate: assert property (@(posedge mclk) disable iff (reset)
    uart_cmd_en |-> (test_mode && !sys_reset))
    else $error("vendor commands enabled outside test mode");

  chk_flag_keeps: assert property (@(posedge mclk) disable iff (reset)
    (test_mode && !clr_test) |=> test_mode)
    else $error("test flag lost across a reset");

endmodule

/* File: rbm_button_model.sv */
`timescale 1ns/10ps
module rbm_button_model (
  // clock
  input  wire logic mclk,
  // bench command: hold the reset button down
  input  wire logic press,
  // device side of the open-drain reset pin
  input  wire logic dev_oe,
  input  wire logic dev_out,
  input  wire logic pullup_en,
  // wire level seen by everyone
  output logic      pin
);
  logic last;
  // the button only ever pulls low, and only while pressed
  wire logic pulled_low = press | (dev_oe & ~dev_out);
  always_ff @(posedge mclk) begin
    last <= pin;
  end
  // without the pull-up a released wire must not keep a trustworthy level
  assign pin = pulled_low ? 1'h0 : (pullup_en ? 1'h1 : ~last);
endmodule

/* File: test_reset_and_boot_mode_control.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module test_reset_and_boot_mode_control import rbm_pkg::*;;
  logic       mclk, reset, wdt, sw_req, press, adap, strap_drv;
  logic       gpio_out, gpio_oe, fw_wr, fw_wdata, seen_oe;
  wire logic  pin, oe, out, pu, sp_out, sp_oe, gpio_in;
  wire logic  test_mode, sys_reset, uart_en, released;
  rbm_cause_t cause;
  int         fail_count, checks;
  // the strap wire follows whoever drives it
  wire logic  strap_wire = sp_oe ? sp_out : strap_drv;

  rbm_reset_ctrl #(.HOLD_CYCLES(4), .PULSE_CYCLES(8)) rbm_reset_ctrl_inst (
    .mclk(mclk), .reset(reset), .watchdog_timeout_src(wdt), .sw_reset_req(sw_req),
    .ext_rst_n_in(pin), .ext_rst_n_out(out), .ext_rst_n_oe(oe), .ext_pullup_en(pu),
    .adapter_supply_in(adap), .mode_strap_pin_in(strap_wire), .mode_strap_pin_out(sp_out),
    .mode_strap_pin_oe(sp_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .fw_flag_wr(fw_wr), .fw_flag_wdata(fw_wdata), .test_mode(test_mode),
    .sys_reset(sys_reset), .uart_cmd_en(uart_en), .strap_released(released),
    .reset_cause(cause));

  rbm_button_model rbm_button_model_inst (
    .mclk(mclk), .press(press), .dev_oe(oe), .dev_out(out), .pullup_en(pu), .pin(pin));

  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  function automatic rbm_cause_t cause_of(input int src);
    rbm_cause_t c;
    c = '0;
    c.ext = (src == 0);
    c.wdt = (src == 1);
    c.sw = (src == 2);
    return c;
  endfunction

  function automatic logic strap_test(input logic a, input logic s);
    return a & (s == STRAP_TEST_LVL);
  endfunction

  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // bounded wait; an expired wait shows up as a mismatch
  task automatic wait_sys(input logic v);
    int n;
    n = 0;
    while (sys_reset !== v && n < 800) begin
      @(negedge mclk);
      seen_oe |= oe;
      n++;
    end
    `CHK(sys_reset, v)
  endtask

  // src 0 pin, 1 watchdog, 2 software; random pulse length
  task automatic fire(input int src);
    int len;
    len = 1 + ($urandom % 3);
    press = (src == 0);
    wdt = (src == 1);
    sw_req = (src == 2);
    repeat (len) @(negedge mclk);
    press = 1'h0;
    wdt = 1'h0;
    sw_req = 1'h0;
    @(negedge mclk);
    if (src != 0) `CHK(sys_reset, 1'h1)
    wait_sys(1'h1);
    `CHK(cause, cause_of(src))
    `CHK(uart_en, 1'h0)
  endtask

  initial begin
    {reset, wdt, sw_req, press, gpio_out, gpio_oe, fw_wr, fw_wdata, seen_oe} = '0;
    reset = 1'h1;
    adap = 1'h1;
    strap_drv = 1'h1;
    void'($urandom(81));
    repeat (16) @(negedge mclk);
    `CHK(sys_reset, 1'h1)
    `CHK(cause, CAUSE_POR)
    `CHK(test_mode, 1'h0)
    `CHK(pu, 1'h1)
    `CHK(oe, 1'h0)
    reset = 1'h0;
    wait_sys(1'h0);
    `CHK(released, !strap_test(adap, strap_drv))
    `CHK(test_mode, strap_test(adap, strap_drv))
    repeat (4) begin
      gpio_out = 1'($urandom);
      gpio_oe = 1'h1;
      repeat (2) @(negedge mclk);
      `CHK(sp_out, gpio_out)
      `CHK(sp_oe, 1'h1)
    end
    repeat (4) @(negedge mclk);
    `CHK(gpio_in, strap_wire)
    gpio_oe = 1'h0;
    for (int s = 0; s < 3; s++) begin
      fire(s);
      wait_sys(1'h0);
    end
    // strap low on adapter power: self-issued pin pulse
    strap_drv = 1'h0;
    fire(1);
    repeat (20) if (oe !== 1'h1) @(negedge mclk);
    `CHK(oe, 1'h1)
    `CHK(out, 1'h0)
    `CHK(pin, 1'h0)
    `CHK(test_mode, 1'h1)
    wait_sys(1'h0);
    `CHK(uart_en, 1'h1)
    `CHK(released, 1'h0)
    // flag already set: no second pulse, flag survives
    seen_oe = 1'h0;
    fire(2);
    wait_sys(1'h0);
    `CHK(seen_oe, 1'h0)
    `CHK(test_mode, 1'h1)
    fw_wr = 1'h1;
    @(negedge mclk);
    fw_wr = 1'h0;
    @(negedge mclk);
    `CHK(test_mode, 1'h0)
    `CHK(uart_en, 1'h0)
    strap_drv = 1'h1;
    fire(0);
    wait_sys(1'h0);
    `CHK(test_mode, 1'h0)
    `CHK(released, 1'h1)
    // strap low without adapter stays in application mode
    adap = 1'h0;
    strap_drv = 1'h0;
    fire(2);
    wait_sys(1'h0);
    `CHK(test_mode, strap_test(adap, strap_drv))
    `CHK(released, 1'h1)
    fw_wr = 1'h1;
    fw_wdata = 1'h1;
    @(negedge mclk);
    fw_wr = 1'h0;
    @(negedge mclk);
    `CHK(uart_en, 1'h1)
    reset = 1'h1;
    repeat (4) @(negedge mclk);
    `CHK(test_mode, 1'h0)
    `CHK(uart_en, 1'h0)
    reset = 1'h0;
    @(negedge mclk);
    `CHK(sys_reset, 1'h1)
    `CHK(cause, CAUSE_POR)
    `CHK(released, 1'h0)
    wait_sys(1'h0);
    `CHK(released, !strap_test(adap, strap_drv))
    test_done;
  end

  initial begin
    #60000;
    fail_count++;
    test_done;
  end
endmodule
